// *** shared/adc_cfg_pkg.sv ***
// constants shared by the converter configuration register bank
package adc_cfg_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_OVERSAMPLE = 8'h03;
   localparam logic [7:0] OFS_OPMODE = 8'h04;
   localparam logic [7:0] OFS_FUNCTION = 8'h05;
   localparam logic [7:0] OFS_DIRECTION = 8'h07;
   localparam logic [7:0] OFS_DRIVE = 8'h09;
   localparam logic [7:0] OFS_OUT_LEVEL = 8'h0B;
   localparam logic [7:0] OFS_IN_LEVEL = 8'h0D;
   localparam logic [7:0] OFS_SCAN_CFG = 8'h10;
   localparam logic [7:0] OFS_MANUAL_CH = 8'h11;
   localparam logic [7:0] OFS_SCAN_EN = 8'h12;
   // ------------------------------------------------------------
   // writable-bit masks; reserved bits are zero here
   // ------------------------------------------------------------
   localparam logic [7:0] MASK_OVERSAMPLE = 8'h07;
   localparam logic [7:0] MASK_OPMODE = 8'h1F;
   localparam logic [7:0] MASK_SCAN_CFG = 8'h13;
   localparam logic [7:0] MASK_MANUAL_CH = 8'h0F;
   localparam logic [7:0] MASK_FULL = 8'hFF;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int OSR_LSB = 0;
   localparam int OSR_MSB = 2;
   localparam int CLKDIV_LSB = 0;
   localparam int CLKDIV_MSB = 3;
   localparam int TIMING_SRC_BIT = 4;
   localparam int SCAN_START_BIT = 4;
   localparam int SCAN_MODE_LSB = 0;
   localparam int SCAN_MODE_MSB = 1;
   localparam int CHID_LSB = 0;
   localparam int CHID_MSB = 3;
   // ------------------------------------------------------------
   // reset value and encodings
   // ------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int NUM_CH = 8;
   localparam logic [1:0] MODE_MANUAL = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h1;
   localparam logic [2:0] LAST_CH = 3'h7;
   // scan sequencer states, one bit so the path is trivially gray
   typedef enum logic [0:0] {
      SCAN_IDLE = 1'b0,
      SCAN_RUN = 1'b1
   } scan_state_e;
endpackage

// *** src/adc_gpio_config_registers.sv ***
// configuration register bank for the eight-channel converter with gpio
//
// Functional notes
// RULE_01: 3-bit oversample code selects averaging count
// RULE_02: reserved bits read zero, writes ignored
// RULE_03: bit 4 picks oscillator, 1 low power
// RULE_04: 4-bit sampling divider in mode low bits
// RULE_05: per-channel bit: 0 analog, 1 gpio
// RULE_06: per-pin direction: 0 input, 1 output
// RULE_07: drive bit: 0 open-drain, 1 push-pull
// RULE_08: outputs follow stored output level bits
// RULE_09: read-only register reports input pin levels
// RULE_10: start bit begins ascending scan, clear stops
// RULE_11: mode 0 manual, 1 auto, others reserved
// RULE_12: all registers reset to zero
// RULE_13: manual channel id selects next conversion
// RULE_14: enable mask picks channels in scan
// RULE_15: force-analog overrides all pin settings
// RULE_16: driver on only for gpio output channels
// RULE_17: advance per conversion, wrap to lowest enabled
`timescale 1ns/1ns
module adc_gpio_config_registers
   import adc_cfg_pkg::*;
(
   input wire logic clk, // 100 MHz system clock
   input wire logic rst_b, // asynchronous reset, active low
   input wire logic reg_wr, // one-cycle write strobe
   input wire logic reg_rd, // one-cycle read strobe
   input wire logic [7:0] reg_addr, // register offset
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata, // read data, valid cycle after strobe
   input wire logic force_all_analog, // forces every channel analog
   input wire logic conversion_done, // pulse from datapath per conversion
   input wire logic [7:0] pin_in, // pad input levels, asynchronous
   output logic [7:0] pin_out, // pad output value
   output logic [7:0] pin_oe, // pad output enable, high drives
   output logic [2:0] oversample_ratio, // averaging code to the filter
   output logic [7:0] average_count, // conversions per result, 0 = none
   output logic timing_source_select, // 0 fast oscillator, 1 low power
   output logic [3:0] clock_divider, // sampling speed divider
   output logic [7:0] analog_enable, // channels acting as analog inputs
   output logic [3:0] conversion_channel, // channel for next conversion
   output logic scan_running // automatic scan in progress
);
   // ------------------------------------------------------------
   // reset synchroniser
   // ------------------------------------------------------------
   logic rst_meta_q; // first stage, read only by the second
   logic rst_sync_q; // released reset used by the register writes and scan sequencer

   // release is synchronous so no register or scan flop sees a partial edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // next enabled channel strictly above cur, wrapping round
   function automatic logic [2:0] next_enabled(input logic [7:0] mask,
                                               input logic [2:0] cur);
      logic [2:0] res;
      logic found;
      logic [2:0] idx;
      res = cur;
      found = 1'b0;
      for (int k = 1; k <= NUM_CH; k++) begin
         idx = 3'(cur + 3'(k));
         if (!found && mask[idx]) begin
            res = idx;
            found = 1'b1;
         end
      end
      return res;
   endfunction

   // masked write of one register, reserved bits stay zero
   function automatic logic [7:0] masked(input logic [7:0] data,
                                         input logic [7:0] mask);
      return data & mask;
   endfunction

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [7:0] oversample_q; // oversample_config
   logic [7:0] opmode_q; // operating_mode_config
   logic [7:0] function_q; // channel_function_select
   logic [7:0] direction_q; // digital_direction_select
   logic [7:0] drive_q; // output_drive_style
   logic [7:0] out_level_q; // output_level
   logic [7:0] scan_cfg_q; // scan_sequence_config
   logic [7:0] manual_ch_q; // manual_channel_select
   logic [7:0] scan_en_q; // scan channel enable mask
   logic [7:0] pin_meta_q; // pad sync first stage
   logic [7:0] pin_sync_q; // pad sync second stage
   logic force_meta_q; // force input sync first stage
   logic force_sync_q; // force input sync second stage

   // software writes; each register keeps only its defined bits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oversample_q <= REG_RESET; // RULE_12
         opmode_q <= REG_RESET;
         function_q <= REG_RESET;
         direction_q <= REG_RESET;
         drive_q <= REG_RESET;
         out_level_q <= REG_RESET;
         scan_cfg_q <= REG_RESET;
         manual_ch_q <= REG_RESET;
         scan_en_q <= REG_RESET;
      end else if (!rst_sync_q) begin
         oversample_q <= REG_RESET; // RULE_12
         opmode_q <= REG_RESET;
         function_q <= REG_RESET;
         direction_q <= REG_RESET;
         drive_q <= REG_RESET;
         out_level_q <= REG_RESET;
         scan_cfg_q <= REG_RESET;
         manual_ch_q <= REG_RESET;
         scan_en_q <= REG_RESET;
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_OVERSAMPLE: begin
               oversample_q <= masked(reg_wdata, MASK_OVERSAMPLE); // RULE_02
            end
            OFS_OPMODE: begin
               opmode_q <= masked(reg_wdata, MASK_OPMODE); // RULE_02
            end
            OFS_FUNCTION: begin
               function_q <= masked(reg_wdata, MASK_FULL); // RULE_05
            end
            OFS_DIRECTION: begin
               direction_q <= masked(reg_wdata, MASK_FULL); // RULE_06
            end
            OFS_DRIVE: begin
               drive_q <= masked(reg_wdata, MASK_FULL); // RULE_07
            end
            OFS_OUT_LEVEL: begin
               out_level_q <= masked(reg_wdata, MASK_FULL); // RULE_08
            end
            OFS_SCAN_CFG: begin
               scan_cfg_q <= masked(reg_wdata, MASK_SCAN_CFG); // RULE_02
            end
            OFS_MANUAL_CH: begin
               manual_ch_q <= masked(reg_wdata, MASK_MANUAL_CH); // RULE_02
            end
            OFS_SCAN_EN: begin
               scan_en_q <= masked(reg_wdata, MASK_FULL); // RULE_14
            end
            default: begin
               // unmapped or read-only offsets: write dropped
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // pads and the force level come from outside the clock domain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_q <= REG_RESET;
         pin_sync_q <= REG_RESET;
         force_meta_q <= 1'b0;
         force_sync_q <= 1'b0;
      end else begin
         pin_meta_q <= pin_in;
         pin_sync_q <= pin_meta_q;
         force_meta_q <= force_all_analog;
         force_sync_q <= force_meta_q;
      end
   end

   // ------------------------------------------------------------
   // effective pin roles
   // ------------------------------------------------------------
   logic [7:0] gpio_eff; // channel is gpio after force override
   logic [7:0] out_eff; // channel is a digital output
   logic [7:0] in_eff; // channel is a digital input
   logic [1:0] scan_mode; // sequencing mode field
   logic scan_start; // sequencing start bit
   logic [7:0] scan_mask; // enabled channels that are analog
   logic auto_go; // conditions for automatic scanning hold

   assign gpio_eff = force_sync_q ? '0 : function_q; // RULE_15
   assign out_eff = gpio_eff & direction_q; // RULE_16
   assign in_eff = gpio_eff & ~direction_q; // RULE_06
   assign scan_mode = scan_cfg_q[SCAN_MODE_MSB:SCAN_MODE_LSB];
   assign scan_start = scan_cfg_q[SCAN_START_BIT];
   // gpio channels are skipped; a conversion there gives no data
   assign scan_mask = scan_en_q & ~gpio_eff; // RULE_14
   // reserved mode codes behave as no sequencing at all
   assign auto_go = (scan_mode == MODE_AUTO) && scan_start; // RULE_11

   // ------------------------------------------------------------
   // pad drive
   // ------------------------------------------------------------
   // open-drain only pulls low; a high level releases the pad
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_pad
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               pin_out[g] <= 1'b0;
               pin_oe[g] <= 1'b0;
            end else if (!out_eff[g]) begin
               pin_out[g] <= 1'b0; // RULE_16
               pin_oe[g] <= 1'b0;
            end else if (drive_q[g]) begin
               pin_out[g] <= out_level_q[g]; // RULE_08
               pin_oe[g] <= 1'b1; // RULE_07
            end else begin
               pin_out[g] <= 1'b0; // RULE_07
               pin_oe[g] <= ~out_level_q[g]; // RULE_08
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // scan sequencer
   // ------------------------------------------------------------
   scan_state_e scan_state_q; // idle or scanning
   logic [2:0] scan_ch_q; // channel of the running scan

   // start from the lowest enabled channel, step on each conversion
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scan_state_q <= SCAN_IDLE;
         scan_ch_q <= 3'h0;
      end else if (!rst_sync_q) begin
         scan_state_q <= SCAN_IDLE;
         scan_ch_q <= 3'h0;
      end else begin
         unique case (scan_state_q)
            SCAN_IDLE: begin
               // nothing enabled: wait rather than convert a gpio pin
               if (auto_go && (scan_mask != '0)) begin
                  scan_state_q <= SCAN_RUN; // RULE_10
                  scan_ch_q <= next_enabled(scan_mask, LAST_CH); // RULE_10
               end
            end
            SCAN_RUN: begin
               if (!auto_go || (scan_mask == '0)) begin
                  scan_state_q <= SCAN_IDLE; // RULE_10
               end else if (conversion_done) begin
                  scan_ch_q <= next_enabled(scan_mask, scan_ch_q); // RULE_17
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // settings driven to the converter
   // ------------------------------------------------------------
   // all registered so every output comes straight from a flop
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oversample_ratio <= 3'h0;
         average_count <= 8'h00;
         timing_source_select <= 1'b0;
         clock_divider <= 4'h0;
         analog_enable <= 8'h00;
         conversion_channel <= 4'h0;
         scan_running <= 1'b0;
      end else begin
         oversample_ratio <= oversample_q[OSR_MSB:OSR_LSB]; // RULE_01
         // code 0 means no averaging, otherwise two to the code
         average_count <= (oversample_q[OSR_MSB:OSR_LSB] == 3'h0) ?
            8'h00 : 8'(1 << oversample_q[OSR_MSB:OSR_LSB]); // RULE_01
         timing_source_select <= opmode_q[TIMING_SRC_BIT]; // RULE_03
         clock_divider <= opmode_q[CLKDIV_MSB:CLKDIV_LSB]; // RULE_04
         analog_enable <= ~gpio_eff; // RULE_05
         if (scan_state_q == SCAN_RUN) begin
            conversion_channel <= {1'b0, scan_ch_q}; // RULE_17
         end else begin
            conversion_channel <= manual_ch_q[CHID_MSB:CHID_LSB]; // RULE_13
         end
         scan_running <= (scan_state_q == SCAN_RUN);
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   // data is captured on the strobe and held until the next read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_OVERSAMPLE: reg_rdata <= oversample_q; // RULE_02
            OFS_OPMODE: reg_rdata <= opmode_q; // RULE_02
            OFS_FUNCTION: reg_rdata <= function_q;
            OFS_DIRECTION: reg_rdata <= direction_q;
            OFS_DRIVE: reg_rdata <= drive_q;
            OFS_OUT_LEVEL: reg_rdata <= out_level_q;
            OFS_IN_LEVEL: reg_rdata <= pin_sync_q & in_eff; // RULE_09
            OFS_SCAN_CFG: reg_rdata <= scan_cfg_q; // RULE_02
            OFS_MANUAL_CH: reg_rdata <= manual_ch_q; // RULE_02
            OFS_SCAN_EN: reg_rdata <= scan_en_q;
            default: reg_rdata <= 8'h00; // unmapped reads zero
         endcase
      end
   end
endmodule

// *** test/adc_cfg_props.sv ***
// concurrent checks on the converter configuration register bank
`timescale 1ns/1ns
module adc_cfg_props
   import adc_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic force_all_analog,
   input wire logic conversion_done,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [2:0] oversample_ratio,
   input wire logic [7:0] average_count,
   input wire logic timing_source_select,
   input wire logic [3:0] clock_divider,
   input wire logic [7:0] analog_enable,
   input wire logic [3:0] conversion_channel,
   input wire logic scan_running
);
   // ------------------------------------------------------------
   // helpers; the mask knows only the hole at 0x06 as unmapped
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] rmask; // readable bits of the addressed register
   assign rmask = (reg_addr == OFS_OVERSAMPLE) ? MASK_OVERSAMPLE
      : (reg_addr == OFS_OPMODE) ? MASK_OPMODE
      : (reg_addr == OFS_SCAN_CFG) ? MASK_SCAN_CFG
      : (reg_addr == OFS_MANUAL_CH) ? MASK_MANUAL_CH
      : (reg_addr == 8'h06) ? 8'h00 : MASK_FULL;
   property p_resv;
      reg_rd |=> (reg_rdata & ~$past(rmask)) == 8'h00;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved bits set");
   // write lands on the strobe edge, outputs one edge after that
   property p_osr_wr;
      reg_wr && reg_addr == OFS_OVERSAMPLE |-> ##2
         {5'h00, oversample_ratio} == ($past(reg_wdata, 2) & 8'h07);
   endproperty
   a_osr_wr: assert property (p_osr_wr) else $error("osr stale");
   property p_mode_wr;
      reg_wr && reg_addr == OFS_OPMODE |-> ##2
         {3'h0, timing_source_select, clock_divider}
         == ($past(reg_wdata, 2) & MASK_OPMODE);
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode stale");
   property p_oe_gpio;
      (pin_oe & analog_enable) == 8'h00;
   endproperty
   a_oe_gpio: assert property (p_oe_gpio)
      else $error("oe on analog");
   property p_od_low;
      (pin_out & ~pin_oe) == 8'h00;
   endproperty
   a_od_low: assert property (p_od_low) else $error("out undriven");
   property p_rst_zero;
      $rose(rst_b) |-> pin_oe == 8'h00 && average_count == 8'h00;
   endproperty
   a_rst_zero: assert property (p_rst_zero)
      else $error("not reset");
   // channel may only move two edges after a conversion pulse
   property p_scan_hold;
      (!conversion_done && !reg_wr)[*3] ##0 scan_running
         |=> scan_running |-> $stable(conversion_channel);
   endproperty
   a_scan_hold: assert property (p_scan_hold)
      else $error("ch moved");
   // write lands, state drops next edge, flag follows one edge later
   property p_stop;
      reg_wr && reg_addr == OFS_SCAN_CFG && (!reg_wdata[SCAN_START_BIT]
         || reg_wdata[1:0] != MODE_AUTO) |-> ##3 !scan_running;
   endproperty
   a_stop: assert property (p_stop) else $error("scan not stopped");
   c_scan: cover property ($rose(scan_running));
   c_hole: cover property (reg_rd && rmask == 8'h00);
   c_force: cover property ($rose(force_all_analog));
endmodule
bind adc_gpio_config_registers adc_cfg_props i_props (.*);

// *** test/adc_pad_model.sv ***
// pad model: far-side drivers and pull-ups on the eight channel pins
`timescale 1ns/1ns
module adc_pad_model (
   input wire logic [7:0] pin_out, // value the device drives
   input wire logic [7:0] pin_oe, // device drive enable
   input wire logic [7:0] ext_en, // far-side driver enable
   input wire logic [7:0] ext_val, // far-side level
   output logic [7:0] pin_in // resolved pad level
);
   // device first, then far side, else pull-up (open drain idles high)
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_en)
      | (~pin_oe & ext_en & ext_val);
endmodule

// *** test/adc_gpio_config_registers_tb.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
module adc_gpio_config_registers_tb;
   import adc_cfg_pkg::*;
   logic clk, rst_b, reg_wr, reg_rd, force_all_analog, conversion_done;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_in, pin_out, pin_oe;
   logic [7:0] average_count, analog_enable, ext_en, ext_val;
   logic [3:0] clock_divider, conversion_channel;
   logic [2:0] oversample_ratio;
   logic timing_source_select, scan_running;
   int miscompares = 0;
   int cmp_count = 0;
   // offset and readable bits; 0x06 is a hole
   logic [15:0] tab [11] = '{16'h0307, 16'h041F, 16'h05FF, 16'h07FF,
      16'h09FF, 16'h0BFF, 16'h0D00, 16'h1013, 16'h110F, 16'h12FF, 16'h0600};
   adc_gpio_config_registers i_dut (.*);
   adc_pad_model i_pads (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle strobes, dropped at the edge that takes them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse();
      @(posedge clk);
      conversion_done <= 1'b1;
      @(posedge clk);
      conversion_done <= 1'b0;
      settle(2);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog: the whole run needs well under 1500 cycles
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
   initial begin
      {rst_b, reg_wr, reg_rd, force_all_analog, conversion_done} = 5'h00;
      {reg_addr, reg_wdata, ext_en, ext_val} = {16'h0000, 8'h0C, 8'h04};
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      settle(3);
      for (int i = 0; i < 11; i++) rdc(tab[i][15:8], 8'h00);
      for (int i = 0; i < 11; i++) wr(tab[i][15:8], 8'hFF);
      for (int i = 0; i < 11; i++) rdc(tab[i][15:8], tab[i][7:0]);
      chk(pin_oe & pin_out, 8'hFF);
      chk({7'h00, scan_running}, 8'h00);
      for (int i = 0; i < 11; i++) wr(tab[i][15:8], 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(OFS_OVERSAMPLE, 8'(c));
         settle(3);
         chk(average_count, (c == 0) ? 8'h00 : 8'h01 << c);
      end
      wr(OFS_OPMODE, 8'h1A);
      settle(3);
      chk({3'h0, timing_source_select, clock_divider}, 8'h1A);
      $display("test registers done");
      // ch0 push-pull out, ch1 open-drain out, ch2-3 inputs
      wr(OFS_FUNCTION, 8'h0F);
      wr(OFS_DIRECTION, 8'h03);
      wr(OFS_DRIVE, 8'h01);
      wr(OFS_OUT_LEVEL, 8'h03);
      settle(3);
      chk({pin_oe[3:0], pin_out[3:0]}, 8'h11);
      chk(analog_enable, 8'hF0);
      rdc(OFS_IN_LEVEL, 8'h04);
      wr(OFS_OUT_LEVEL, 8'h00);
      settle(3);
      chk({pin_oe[3:0], pin_out[3:0]}, 8'h30);
      @(posedge clk) force_all_analog <= 1'b1;
      settle(6);
      chk(pin_oe | ~analog_enable, 8'h00);
      @(posedge clk) force_all_analog <= 1'b0;
      wr(OFS_FUNCTION, 8'h00);
      $display("test pads done");
      // scan over channels 1 and 3, then back to manual channel 5
      wr(OFS_MANUAL_CH, 8'h05);
      wr(OFS_SCAN_EN, 8'h0A);
      wr(OFS_SCAN_CFG, 8'h11);
      settle(3);
      chk({3'h0, scan_running, conversion_channel}, 8'h11);
      pulse();
      chk({3'h0, scan_running, conversion_channel}, 8'h13);
      pulse();
      chk({3'h0, scan_running, conversion_channel}, 8'h11);
      wr(OFS_SCAN_CFG, 8'h01);
      settle(3);
      chk({3'h0, scan_running, conversion_channel}, 8'h05);
      $display("test scan done");
      end_of_test();
   end
endmodule
